/* verilog/tlc_cfg.svh */
`ifndef TLC_CFG_SVH
`define TLC_CFG_SVH
// ==========================================
// Register offsets (byte addresses)
`define TLC_ADDR_W           12
`define TLC_OFS_SYS_PATH     12'h040
`define TLC_OFS_COPROC_SLOW  12'h04c
`define TLC_OFS_CPU_PATH     12'h050
`define TLC_OFS_DEBUG_WIRE   12'h05c
`define TLC_OFS_GENERAL      12'h104
`define TLC_OFS_FABRIC_VOICE 12'h11c
`define TLC_OFS_AUDIO        12'h120
`define TLC_OFS_DIV_INPUT    12'h124
// ==========================================
// Field widths
`define TLC_DIV_W            10
`define TLC_GEN_W            8
`define TLC_SYS_W            10
`define TLC_CPU_W            7
`define TLC_FAB_W            3
`define TLC_CPS_W            4
`define TLC_AUD_W            4
`define TLC_SRAM_GROUPS      4
`define TLC_BANKS_PER_GROUP  4
// ==========================================
// Reset values
`define TLC_RST_DIV_INPUT    10'h3ff
`define TLC_RST_GENERAL      8'h00
`define TLC_RST_SYS_PATH     10'h291
`define TLC_RST_CPU_PATH     7'h43
`define TLC_RST_FABRIC_VOICE 3'h0
`define TLC_RST_COPROC_SLOW  4'h0
`define TLC_RST_AUDIO        4'h0
`define TLC_RST_DEBUG_WIRE   1'h1
// ==========================================
// Field positions
`define TLC_GEN_SPI_KEEP     0
`define TLC_SYS_RO_BIT       0
`define TLC_CPU_RO_BIT       0
`define TLC_CPU_SRAM_LSB     1
`define TLC_CPS_SLOW_BIT     0
`define TLC_DIV_COPROC_BIT   2
// ==========================================
// Coprocessor slow clock divide factor
`define TLC_SLOW_DIV         4
`define TLC_SLOW_CNT_W       2
`endif

/* verilog/tlc_pkg.sv */
`default_nettype none
`include "tlc_cfg.svh"
package tlc_pkg;
	// ==========================================
	// Register bus request
	typedef struct packed {
		logic [`TLC_ADDR_W-1:0] addr;
		logic [31:0]            wdata;
		logic                   wr;
		logic                   rd;
	} tlc_bus_req_t;

	// ==========================================
	// Gate enables toward the clock gating cells
	typedef struct packed {
		logic [`TLC_DIV_W-1:0] divider_input;
		logic [`TLC_SYS_W-1:0] system_path;
		logic [`TLC_CPU_W-1:0] cpu_domain;
		logic [`TLC_FAB_W-1:0] fabric_voice;
		logic [`TLC_CPS_W-1:0] coproc_slow;
		logic [`TLC_AUD_W-1:0] audio;
		logic                  debug_wire;
	} tlc_gates_t;
endpackage
`default_nettype wire

/* verilog/tlc_clock_gating.sv */
// Implementation choice: the address-and-strobe port.
`default_nettype none
`include "tlc_cfg.svh"
module tlc_clock_gating
	import tlc_pkg::*;
(
	// Clock and reset
	input  wire logic                           clk,
	input  wire logic                           rst,
	// Register port
	input  wire tlc_bus_req_t                   bus_req,
	output logic [31:0]                         bus_rdata,
	// SPI pad side
	input  wire logic                           spi_pad_clk,
	input  wire logic                           spi_cs_n,
	output logic                                internal_spi_clock,
	// Debug wire pad side
	input  wire logic                           debug_pad_clk,
	output logic                                debug_wire_clock,
	// SRAM wakeup
	input  wire logic [`TLC_SRAM_GROUPS*`TLC_BANKS_PER_GROUP-1:0] sram_access,
	input  wire logic [`TLC_SRAM_GROUPS*`TLC_BANKS_PER_GROUP-1:0] sram_sleep,
	output logic [`TLC_SRAM_GROUPS*`TLC_BANKS_PER_GROUP-1:0]      sram_power_on,
	// Gate enables and coprocessor slow tick
	output tlc_gates_t                          gates,
	output logic                                coproc_slow_tick
);
	localparam int NB = `TLC_SRAM_GROUPS * `TLC_BANKS_PER_GROUP;

	// ==========================================
	// Register storage
	logic [`TLC_DIV_W-1:0] div_q;
	logic [`TLC_GEN_W-1:0] gen_q;
	logic [`TLC_SYS_W-1:0] sys_q;
	logic [`TLC_CPU_W-1:0] cpu_q;
	logic [`TLC_CPU_W-1:0] cpu_d;
	logic [`TLC_FAB_W-1:0] fab_q;
	logic [`TLC_CPS_W-1:0] cps_q;
	logic [`TLC_AUD_W-1:0] aud_q;
	logic                  dbg_q;
	logic [NB-1:0]         bank_on_q;
	logic [`TLC_SRAM_GROUPS-1:0] group_wake;

	// ==========================================
	// Write decode
	logic wr_div;
	logic wr_gen;
	logic wr_sys;
	logic wr_cpu;
	logic wr_fab;
	logic wr_cps;
	logic wr_aud;
	logic wr_dbg;

	assign wr_div = bus_req.wr && bus_req.addr == `TLC_OFS_DIV_INPUT;
	assign wr_gen = bus_req.wr && bus_req.addr == `TLC_OFS_GENERAL;
	assign wr_sys = bus_req.wr && bus_req.addr == `TLC_OFS_SYS_PATH;
	assign wr_cpu = bus_req.wr && bus_req.addr == `TLC_OFS_CPU_PATH;
	assign wr_fab = bus_req.wr && bus_req.addr == `TLC_OFS_FABRIC_VOICE;
	assign wr_cps = bus_req.wr && bus_req.addr == `TLC_OFS_COPROC_SLOW;
	assign wr_aud = bus_req.wr && bus_req.addr == `TLC_OFS_AUDIO;
	assign wr_dbg = bus_req.wr && bus_req.addr == `TLC_OFS_DEBUG_WIRE;

	// Divider input gates, bit 2 also runs the slow counter
	always_ff @(posedge clk) begin
		if (rst) begin
			div_q <= `TLC_RST_DIV_INPUT;
		end else if (wr_div) begin
			div_q <= bus_req.wdata[`TLC_DIV_W-1:0];
		end
	end

	// Keep-running bit plus general storage
	always_ff @(posedge clk) begin
		if (rst) begin
			gen_q <= `TLC_RST_GENERAL;
		end else if (wr_gen) begin
			gen_q <= bus_req.wdata[`TLC_GEN_W-1:0];
		end
	end

	// System path gates, bit 0 fixed at 1
	always_ff @(posedge clk) begin
		if (rst) begin
			sys_q <= `TLC_RST_SYS_PATH;
		end else if (wr_sys) begin
			sys_q <= bus_req.wdata[`TLC_SYS_W-1:0] | 10'h001;
		end
	end

	// ==========================================
	// SRAM auto wakeup
	genvar g;
	generate
		for (g = 0; g < NB; g++) begin : g_bank
			always_ff @(posedge clk) begin
				if (rst) begin
					bank_on_q[g] <= 1'b0;
				end else if (sram_access[g]) begin
					bank_on_q[g] <= 1'b1;
				end else if (sram_sleep[g]) begin
					bank_on_q[g] <= 1'b0;
				end
			end
		end
		for (g = 0; g < `TLC_SRAM_GROUPS; g++) begin : g_group
			// Wake of a sleeping bank in this group
			assign group_wake[g] = |(sram_access[g*4 +: 4]
				& ~bank_on_q[g*4 +: 4]);
		end
	endgenerate

	// Processor path: hardware set wins over a software clear
	always_comb begin
		cpu_d = cpu_q;
		if (wr_cpu) begin
			cpu_d = bus_req.wdata[`TLC_CPU_W-1:0];
		end
		cpu_d[`TLC_CPU_SRAM_LSB +: `TLC_SRAM_GROUPS] =
			cpu_d[`TLC_CPU_SRAM_LSB +: `TLC_SRAM_GROUPS]
			| group_wake;
		cpu_d[`TLC_CPU_RO_BIT] = 1'b1;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cpu_q <= `TLC_RST_CPU_PATH;
		end else begin
			cpu_q <= cpu_d;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			fab_q <= `TLC_RST_FABRIC_VOICE;
		end else if (wr_fab) begin
			fab_q <= bus_req.wdata[`TLC_FAB_W-1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cps_q <= `TLC_RST_COPROC_SLOW;
		end else if (wr_cps) begin
			cps_q <= bus_req.wdata[`TLC_CPS_W-1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			aud_q <= `TLC_RST_AUDIO;
		end else if (wr_aud) begin
			aud_q <= bus_req.wdata[`TLC_AUD_W-1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			dbg_q <= `TLC_RST_DEBUG_WIRE;
		end else if (wr_dbg) begin
			dbg_q <= bus_req.wdata[0];
		end
	end

	// ==========================================
	// Read port, one cycle latency
	always_ff @(posedge clk) begin
		if (rst) begin
			bus_rdata <= 32'h0000_0000;
		end else if (!bus_req.rd) begin
			bus_rdata <= 32'h0000_0000;
		end else if (bus_req.addr == `TLC_OFS_DIV_INPUT) begin
			bus_rdata <= {22'h0, div_q};
		end else if (bus_req.addr == `TLC_OFS_GENERAL) begin
			bus_rdata <= {24'h0, gen_q};
		end else if (bus_req.addr == `TLC_OFS_SYS_PATH) begin
			bus_rdata <= {22'h0, sys_q};
		end else if (bus_req.addr == `TLC_OFS_CPU_PATH) begin
			bus_rdata <= {25'h0, cpu_q};
		end else if (bus_req.addr == `TLC_OFS_FABRIC_VOICE) begin
			bus_rdata <= {29'h0, fab_q};
		end else if (bus_req.addr == `TLC_OFS_COPROC_SLOW) begin
			bus_rdata <= {28'h0, cps_q};
		end else if (bus_req.addr == `TLC_OFS_AUDIO) begin
			bus_rdata <= {28'h0, aud_q};
		end else if (bus_req.addr == `TLC_OFS_DEBUG_WIRE) begin
			bus_rdata <= {31'h0, dbg_q};
		end else begin
			bus_rdata <= 32'h0000_0000;
		end
	end

	// ==========================================
	// Pad clock synchronisers
	logic [1:0] spi_clk_s;
	logic [1:0] spi_cs_s;
	logic [1:0] dbg_clk_s;
	logic       spi_en_q;
	logic       dbg_en_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			spi_clk_s <= 2'h0;
			spi_cs_s  <= 2'h3;
			dbg_clk_s <= 2'h0;
		end else begin
			spi_clk_s <= {spi_clk_s[0], spi_pad_clk};
			spi_cs_s  <= {spi_cs_s[0], spi_cs_n};
			dbg_clk_s <= {dbg_clk_s[0], debug_pad_clk};
		end
	end

	// Enables move only while the pad clock is low
	always_ff @(posedge clk) begin
		if (rst) begin
			spi_en_q <= 1'b0;
		end else if (!spi_clk_s[1]) begin
			spi_en_q <= gen_q[`TLC_GEN_SPI_KEEP] || !spi_cs_s[1];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			dbg_en_q <= `TLC_RST_DEBUG_WIRE;
		end else if (!dbg_clk_s[1]) begin
			dbg_en_q <= dbg_q;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			internal_spi_clock <= 1'b0;
			debug_wire_clock   <= 1'b0;
		end else begin
			internal_spi_clock <= spi_clk_s[1] && spi_en_q;
			debug_wire_clock   <= dbg_clk_s[1] && dbg_en_q;
		end
	end

	// ==========================================
	// Coprocessor slow clock, fast clock / 4
	logic [`TLC_SLOW_CNT_W-1:0] slow_cnt_q;
	logic                       slow_en_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			slow_cnt_q <= '0;
		end else if (div_q[`TLC_DIV_COPROC_BIT]) begin
			slow_cnt_q <= slow_cnt_q + 1'b1;
		end
	end

	// Slow gate enable moves only away from the tick
	always_ff @(posedge clk) begin
		if (rst) begin
			slow_en_q <= 1'b0;
		end else if (slow_cnt_q == 2'h1) begin
			slow_en_q <= cps_q[`TLC_CPS_SLOW_BIT];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			coproc_slow_tick <= 1'b0;
		end else begin
			coproc_slow_tick <= div_q[`TLC_DIV_COPROC_BIT] && slow_en_q
				&& slow_cnt_q == 2'(`TLC_SLOW_DIV - 1);
		end
	end

	// ==========================================
	// Gate enable outputs, straight from registers
	assign sram_power_on       = bank_on_q;
	assign gates.divider_input = div_q;
	assign gates.system_path   = sys_q;
	assign gates.cpu_domain    = cpu_q;
	assign gates.fabric_voice  = fab_q;
	assign gates.coproc_slow   = cps_q;
	assign gates.audio         = aud_q;
	assign gates.debug_wire    = dbg_q;
endmodule
`default_nettype wire

/* tb/tlc_gating_chk.sv */
`default_nettype none
`include "tlc_cfg.svh"
module tlc_gating_chk
	import tlc_pkg::*;
(
	// Clock and reset
	input wire logic         clk,
	input wire logic         rst,
	// Register port
	input wire tlc_bus_req_t bus_req,
	input wire logic [31:0]  bus_rdata,
	// Wakeup and gate outputs
	input wire logic [15:0]  sram_access,
	input wire logic [15:0]  sram_power_on,
	input wire tlc_gates_t   gates,
	input wire logic         coproc_slow_tick
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// ==========================================
	// Register side
	a_rdata_idle: assert property (!$past(bus_req.rd) |-> !bus_rdata)
		else $error("read data not idle");
	a_div_write: assert property (bus_req.wr &&
		bus_req.addr == `TLC_OFS_DIV_INPUT |=>
		gates.divider_input == $past(bus_req.wdata[9:0]))
		else $error("divider gates not written");
	a_aud_write: assert property (bus_req.wr &&
		bus_req.addr == `TLC_OFS_AUDIO |=>
		gates.audio == $past(bus_req.wdata[3:0]))
		else $error("audio gates not written");
	a_ro_bits: assert property (gates.system_path[0] &&
		gates.cpu_domain[0]) else $error("read-only gate low");
	a_gate_hold: assert property (!bus_req.wr && !sram_access |=>
		$stable(gates)) else $error("gates moved unasked");

	// ==========================================
	// Bank wakeup
	for (genvar g = 0; g < 4; g++) begin : grp
		a_wake_grp: assert property (|(sram_access[4*g+:4] &
			~sram_power_on[4*g+:4]) |=> gates.cpu_domain[g+1])
			else $error("group gate not set");
	end
	a_bank_on: assert property (|sram_access |=>
		(sram_power_on & $past(sram_access)) == $past(sram_access))
		else $error("bank not powered");

	// ==========================================
	// Slow tick
	a_tick_gap: assert property (coproc_slow_tick |=>
		!coproc_slow_tick [*3]) else $error("tick period short");
	a_tick_off: assert property ((!gates.coproc_slow[0]) [*5] |=>
		!coproc_slow_tick) else $error("tick while gated");
endmodule
`default_nettype wire

/* tb/two_level_clock_gating_test.sv */
`default_nettype none
`include "tlc_cfg.svh"
module two_level_clock_gating_test
	import tlc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic         clk, rst, spi_pad_clk, spi_cs_n, debug_pad_clk;
	logic         internal_spi_clock, debug_wire_clock, coproc_slow_tick;
	tlc_bus_req_t bus_req;
	tlc_gates_t   gates;
	logic [31:0]  bus_rdata, d;
	logic [15:0]  sram_access, sram_sleep, sram_power_on;
	int           fails = 0, cmp_count = 0, cyc = 0;
	int           spi_n = 0, dbg_n = 0, tick_n = 0;
	logic [31:0]  m [9];
	logic [11:0]  ofs [9] = '{12'h040, 12'h04c, 12'h050, 12'h05c,
		12'h104, 12'h11c, 12'h120, 12'h124, 12'h200};
	logic [31:0]  msk [9] = '{32'h3ff, 32'hf, 32'h7f, 32'h1,
		32'hff, 32'h7, 32'hf, 32'h3ff, 32'h0};

	tlc_clock_gating tlc_clock_gating_inst (.clk, .rst, .bus_req,
		.bus_rdata, .spi_pad_clk, .spi_cs_n, .internal_spi_clock,
		.debug_pad_clk, .debug_wire_clock, .sram_access, .sram_sleep,
		.sram_power_on, .gates, .coproc_slow_tick);

	// ==========================================
	// Clock, counters and hang limit
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge internal_spi_clock) spi_n++;
	always @(posedge debug_wire_clock) dbg_n++;
	always @(posedge clk) begin
		tick_n += coproc_slow_tick;
		cyc++;
		if (cyc == 6000) begin
			fails++;
			results();
		end
	end

	// ==========================================
	// Tasks
	task automatic chk(input logic [63:0] s, e);
		cmp_count++;
		if (s !== e) begin
			fails++;
			$display("ERROR %0t seen %h exp %h", $time, s, e);
		end
	endtask
	task automatic init_model;
		m = '{32'h291, 32'h0, 32'h43, 32'h1, 32'h0, 32'h0, 32'h0,
			32'h3ff, 32'h0};
	endtask
	task automatic wr(input int i, input logic [31:0] v);
		@(posedge clk);
		bus_req <= '{ofs[i], v, 1'b1, 1'b0};
		@(posedge clk);
		bus_req.wr <= 1'b0;
		m[i] = v & msk[i] | (i == 0 || i == 2);
	endtask
	task automatic rd(input int i);
		@(posedge clk);
		bus_req <= '{ofs[i], 32'h0, 1'b0, 1'b1};
		@(posedge clk);
		bus_req.rd <= 1'b0;
		#1 chk(bus_rdata, m[i]);
	endtask
	task automatic cg;
		chk(64'(gates), 64'({m[7][9:0], m[0][9:0], m[2][6:0], m[5][2:0],
			m[1][3:0], m[6][3:0], m[3][0]}));
	endtask
	task automatic tog(input int n);
		repeat (n) begin
			@(posedge clk);
			spi_pad_clk <= ~spi_pad_clk;
			debug_pad_clk <= ~debug_pad_clk;
			@(posedge clk);
		end
	endtask
	task automatic cnt(input int n, input logic on);
		chk(n > 15 && n < 22, on);
		chk(n == 0, !on);
	endtask
	task automatic results;
		if (fails == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// ==========================================
	// Main sequence
	initial begin
		rst = 1'b1;
		bus_req = '0;
		spi_pad_clk = 1'b0;
		spi_cs_n = 1'b1;
		debug_pad_clk = 1'b0;
		sram_access = '0;
		sram_sleep = '0;
		void'($urandom(76));
		init_model();
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		for (int k = 0; k < 9; k++) rd(k);
		repeat (3) for (int k = 0; k < 9; k++) begin
			d = $urandom;
			if (k == 7) d[0] = 1'b1;
			if (k == 2) d[4:1] = 4'h0;
			wr(k, d);
			rd(k);
			cg();
		end
		for (int b = 0; b < 16; b += 5) begin
			wr(2, 32'h41);
			sram_access <= 16'h1 << b;
			@(posedge clk);
			sram_access <= '0;
			m[2] |= 1 << (1 + b / 4);
			#1 chk(sram_power_on[b], 1'b1);
			cg();
		end
		// Access to a bank already awake leaves the group bit alone
		wr(2, 32'h1);
		sram_access <= 16'h1;
		@(posedge clk);
		sram_access <= '0;
		#1 cg();
		@(posedge clk);
		sram_sleep <= 16'hffff;
		@(posedge clk);
		sram_sleep <= '0;
		#1 chk(sram_power_on, 16'h0);
		wr(7, 32'h3ff);
		for (int c = 0; c < 4; c++) begin
			wr(4, c[0]);
			wr(3, c[0]);
			wr(1, c[0]);
			spi_cs_n <= c[1];
			tog(4);
			spi_n = 0;
			dbg_n = 0;
			tick_n = 0;
			tog(40);
			cnt(spi_n, !c[1] || c[0]);
			cnt(dbg_n, c[0]);
			cnt(tick_n, c[0]);
		end
		wr(7, 32'h3fb);
		tog(4);
		tick_n = 0;
		tog(40);
		cnt(tick_n, 1'b0);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		init_model();
		rd(7);
		cg();
		results();
	end
endmodule

bind tlc_clock_gating tlc_gating_chk tlc_gating_chk_inst (.clk, .rst,
	.bus_req, .bus_rdata, .sram_access, .sram_power_on, .gates,
	.coproc_slow_tick);
`default_nettype wire
